// ==== rtl/afcl_pkg.sv ====
// constants for the automatic fan curve limit block
//
// How it works
// - one eight-bit ceiling duty per output
// - ceiling count 0xFF means full duty
// - duty rises linearly across linear span temperature
// - four-bit span field per channel, bits 7:4
// - span codes map to 2 through 80 degrees
// - ceiling clips output, curve slope unchanged
// - output steps gradually toward curve target
// - any channel over critical limit: full duty
// - full duty holds until below limit minus hysteresis
// - critical override ignores all fan curve settings
// - critical limits reset 0x64, cpu bus 0x00
// - one hysteresis serves fan off and override
// - hysteresis fields packed two per register
// - hysteresis zero disables hysteresis
// - above fan on temperature start at floor
// - output never above ceiling outside override
package afcl_pkg;

    localparam int NUM_CH = 4;
    localparam int NUM_PWM = 3;
    localparam int SEL_W = 2;

    localparam logic [7:0] ADDR_MAX_DUTY [NUM_PWM] = '{8'h38, 8'h39, 8'h3A};
    // channel order: remote 1, local, remote 2, cpu bus
    localparam logic [7:0] ADDR_RANGE [NUM_CH] = '{8'h5F, 8'h60, 8'h61, 8'h3C};
    localparam logic [7:0] ADDR_LIMIT [NUM_CH] = '{8'h6A, 8'h6B, 8'h6C, 8'h3D};
    localparam logic [7:0] ADDR_HYST_A = 8'h6D;
    localparam logic [7:0] ADDR_HYST_B = 8'h6E;

    localparam logic [7:0] RST_MAX_DUTY = 8'hFF;
    localparam logic [7:0] RST_RANGE = 8'hC0;
    localparam logic [7:0] RST_LIMIT [NUM_CH] = '{8'h64, 8'h64, 8'h64, 8'h00};
    localparam logic [7:0] RST_HYST = 8'h44;

    localparam logic [7:0] DUTY_FULL = 8'hFF;
    localparam logic [7:0] DUTY_OFF = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    localparam int RANGE_MSB = 7;
    localparam int RANGE_LSB = 4;
    localparam int HYST_HI_MSB = 7;
    localparam int HYST_HI_LSB = 4;
    localparam int HYST_LO_MSB = 3;
    localparam int HYST_LO_LSB = 0;

    // span in sixths of a degree, so every code is a whole number
    localparam logic [19:0] SIXTHS_PER_DEG = 20'h00006;
    localparam logic [8:0] SPAN_SIXTHS [16] = '{
        9'h00C, 9'h00F, 9'h014, 9'h018, 9'h01E, 9'h028, 9'h030, 9'h03C,
        9'h050, 9'h060, 9'h078, 9'h0A0, 9'h0C0, 9'h0F0, 9'h140, 9'h1E0};

    localparam logic [15:0] TICK_ZERO = 16'h0000;
    localparam logic [15:0] TICK_ONE = 16'h0001;

endpackage : afcl_pkg

// ==== rtl/afcl_top.sv ====
// automatic fan curve duty, ceiling, ramp and critical override
`timescale 1ns/10ps
`default_nettype none

module afcl_top
    import afcl_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic [afcl_pkg::NUM_CH-1:0][7:0] temp_value,
    input wire logic [afcl_pkg::NUM_CH-1:0] temp_valid,
    input wire logic [afcl_pkg::NUM_CH-1:0][7:0] fan_on_temperature,
    input wire logic [afcl_pkg::NUM_PWM-1:0][7:0] floor_duty,
    input wire logic [afcl_pkg::NUM_PWM-1:0][afcl_pkg::SEL_W-1:0] pwm_source,
    input wire logic [15:0] ramp_step_cycles,
    output logic [afcl_pkg::NUM_PWM-1:0][7:0] pwm_duty,
    output logic overtemperature_flag
);
    import afcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [7:0] max_duty [NUM_PWM];
    logic [7:0] range_cfg [NUM_CH];
    logic [7:0] crit_limit [NUM_CH];
    logic [7:0] hyst_a;
    logic [7:0] hyst_b;
    logic [7:0] rd_value;
    logic [3:0] hyst_of [NUM_CH];

    wire wr_hyst_a = reg_write && (reg_addr == ADDR_HYST_A);
    wire wr_hyst_b = reg_write && (reg_addr == ADDR_HYST_B);

    // per-channel hysteresis fields
    assign hyst_of[0] = hyst_a[HYST_HI_MSB:HYST_HI_LSB];
    assign hyst_of[1] = hyst_a[HYST_LO_MSB:HYST_LO_LSB];
    assign hyst_of[2] = hyst_b[HYST_HI_MSB:HYST_HI_LSB];
    assign hyst_of[3] = hyst_b[HYST_LO_MSB:HYST_LO_LSB];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PWM; gi++) begin : g_max
            wire wr_max = reg_write && (reg_addr == ADDR_MAX_DUTY[gi]);
            always_ff @(posedge clk) begin
                if (reset) begin
                    max_duty[gi] <= RST_MAX_DUTY;
                end else if (wr_max) begin
                    max_duty[gi] <= reg_wdata;
                end
            end
        end
        for (gi = 0; gi < NUM_CH; gi++) begin : g_cfg
            wire wr_range = reg_write && (reg_addr == ADDR_RANGE[gi]);
            wire wr_limit = reg_write && (reg_addr == ADDR_LIMIT[gi]);
            always_ff @(posedge clk) begin
                if (reset) begin
                    range_cfg[gi] <= RST_RANGE;
                    crit_limit[gi] <= RST_LIMIT[gi];
                end else begin
                    if (wr_range) begin
                        range_cfg[gi] <= reg_wdata;
                    end
                    if (wr_limit) begin
                        crit_limit[gi] <= reg_wdata;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            hyst_a <= RST_HYST;
            hyst_b <= RST_HYST;
        end else begin
            if (wr_hyst_a) begin
                hyst_a <= reg_wdata;
            end
            if (wr_hyst_b) begin
                hyst_b <= reg_wdata;
            end
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        rd_value = READ_ZERO;
        for (int i = 0; i < NUM_PWM; i++) begin
            if (reg_addr == ADDR_MAX_DUTY[i]) begin
                rd_value = max_duty[i];
            end
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (reg_addr == ADDR_RANGE[i]) begin
                rd_value = range_cfg[i];
            end
            if (reg_addr == ADDR_LIMIT[i]) begin
                rd_value = crit_limit[i];
            end
        end
        if (reg_addr == ADDR_HYST_A) begin
            rd_value = hyst_a;
        end
        if (reg_addr == ADDR_HYST_B) begin
            rd_value = hyst_b;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= READ_ZERO;
        end else if (reg_read) begin
            reg_rdata <= rd_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // channel state: latched reading, fan on, critical override

    logic signed [7:0] temp_latch [NUM_CH];
    logic on_flag [NUM_CH];
    logic crit_flag [NUM_CH];

    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            wire signed [9:0] t_now = 10'(signed'(temp_value[gi]));
            wire signed [9:0] t_min = 10'(signed'(fan_on_temperature[gi]));
            wire signed [9:0] t_lim = 10'(signed'(crit_limit[gi]));
            wire signed [9:0] t_hys = signed'({6'h00, hyst_of[gi]});
            // zero hysteresis makes the release point equal the set point
            wire above_min = t_now > t_min;
            wire below_off = t_now < (t_min - t_hys);
            wire above_lim = t_now > t_lim;
            wire below_rel = t_now < (t_lim - t_hys);
            always_ff @(posedge clk) begin
                if (reset) begin
                    temp_latch[gi] <= 8'sh00;
                    on_flag[gi] <= 1'b0;
                    crit_flag[gi] <= 1'b0;
                end else if (temp_valid[gi]) begin
                    temp_latch[gi] <= signed'(temp_value[gi]);
                    if (above_min) begin
                        on_flag[gi] <= 1'b1;
                    end else if (below_off) begin
                        on_flag[gi] <= 1'b0;
                    end
                    if (above_lim) begin
                        crit_flag[gi] <= 1'b1;
                    end else if (below_rel) begin
                        crit_flag[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // override is independent of every curve setting
    wire crit_any = crit_flag[0] | crit_flag[1] | crit_flag[2]
        | crit_flag[3];

    ////////////////////////////////////////////////////////////////////////
    // ramp tick

    logic [15:0] tick_count;
    wire ramp_tick = tick_count >= ramp_step_cycles;
    wire [15:0] next_tick_count = ramp_tick ? TICK_ZERO
        : tick_count + TICK_ONE;

    always_ff @(posedge clk) begin
        if (reset) begin
            tick_count <= TICK_ZERO;
        end else begin
            tick_count <= next_tick_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-output curve, ramp and clip

    logic [7:0] target [NUM_PWM];
    logic [7:0] ramp_duty [NUM_PWM];

    generate
        for (gi = 0; gi < NUM_PWM; gi++) begin : g_pwm
            wire [SEL_W-1:0] src = pwm_source[gi];
            wire signed [9:0] delta = 10'(temp_latch[src])
                - 10'(signed'(fan_on_temperature[src]));
            wire [7:0] headroom = DUTY_FULL - floor_duty[gi];
            wire [8:0] span
                = SPAN_SIXTHS[range_cfg[src][RANGE_MSB:RANGE_LSB]];
            // slope set by floor and span only, never by the ceiling
            wire [19:0] rise_num = 20'(delta[7:0]) * SIXTHS_PER_DEG
                * 20'(headroom);
            wire [19:0] rise = rise_num / 20'(span);
            wire [19:0] curve_sum = 20'(floor_duty[gi]) + rise;
            wire [7:0] curve = (curve_sum > 20'(DUTY_FULL)) ? DUTY_FULL
                : curve_sum[7:0];
            wire on_now = on_flag[src];
            wire [7:0] next_target = !on_now ? DUTY_OFF
                : (delta <= 10'sd0) ? floor_duty[gi] : curve;
            wire [7:0] next_ramp = !ramp_tick ? ramp_duty[gi]
                : (ramp_duty[gi] < target[gi]) ? ramp_duty[gi] + 8'h01
                : (ramp_duty[gi] > target[gi]) ? ramp_duty[gi] - 8'h01
                : ramp_duty[gi];
            wire [7:0] clipped = (ramp_duty[gi] > max_duty[gi])
                ? max_duty[gi] : ramp_duty[gi];
            wire [7:0] next_duty = crit_any ? DUTY_FULL : clipped;
            assign target[gi] = next_target;
            always_ff @(posedge clk) begin
                if (reset) begin
                    ramp_duty[gi] <= DUTY_OFF;
                    pwm_duty[gi] <= DUTY_OFF;
                end else begin
                    ramp_duty[gi] <= next_ramp;
                    pwm_duty[gi] <= next_duty;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            overtemperature_flag <= 1'b0;
        end else begin
            overtemperature_flag <= crit_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    wire signed [9:0] chk_t0 = 10'(signed'(temp_value[0]));
    wire signed [9:0] chk_min0 = 10'(signed'(fan_on_temperature[0]));
    wire signed [9:0] chk_hys0 = signed'({6'h00, hyst_of[0]});
    wire signed [9:0] chk_t1 = 10'(signed'(temp_value[1]));
    wire signed [9:0] chk_lim1 = 10'(signed'(crit_limit[1]));
    wire signed [9:0] chk_hys1 = signed'({6'h00, hyst_of[1]});
    // plain compare results, so that past values are taken of signals
    wire chk_on0 = chk_t0 > chk_min0;
    wire chk_off0 = chk_t0 < (chk_min0 - chk_hys0);
    wire chk_over1 = chk_t1 > chk_lim1;
    wire chk_rel1 = chk_t1 < (chk_lim1 - chk_hys1);

    property p_full_on_crit;
        crit_any |=> (pwm_duty[0] == DUTY_FULL) && (pwm_duty[1] == DUTY_FULL)
            && (pwm_duty[2] == DUTY_FULL) && overtemperature_flag;
    endproperty
    a_full_on_crit: assert property (p_full_on_crit)
        else $error("duty not full during critical override");

    property p_crit_set;
        $rose(crit_flag[1]) |-> $past(temp_valid[1])
            && $past(chk_over1);
    endproperty
    a_crit_set: assert property (p_crit_set)
        else $error("override raised without reading over limit");

    property p_crit_release;
        $fell(crit_flag[1]) |-> $past(temp_valid[1])
            && $past(chk_rel1);
    endproperty
    a_crit_release: assert property (p_crit_release)
        else $error("override released above hysteresis point");

    property p_crit_must_set;
        temp_valid[1] && chk_over1 |=> crit_flag[1];
    endproperty
    a_crit_must_set: assert property (p_crit_must_set)
        else $error("new reading over limit not acted on");

    property p_fan_on;
        $rose(on_flag[0]) |-> $past(temp_valid[0])
            && $past(chk_on0);
    endproperty
    a_fan_on: assert property (p_fan_on)
        else $error("fan switched on at or below on temperature");

    property p_fan_off;
        $fell(on_flag[0]) |-> $past(chk_off0);
    endproperty
    a_fan_off: assert property (p_fan_off)
        else $error("fan switched off inside hysteresis band");

    property p_ceiling;
        !crit_any |=> pwm_duty[0] <= $past(max_duty[0]);
    endproperty
    a_ceiling: assert property (p_ceiling)
        else $error("duty above ceiling outside override");

    property p_ramp_step;
        (ramp_duty[1] != $past(ramp_duty[1])) |-> $past(ramp_tick)
            && ((ramp_duty[1] - $past(ramp_duty[1]) == 8'h01)
            || ($past(ramp_duty[1]) - ramp_duty[1] == 8'h01));
    endproperty
    a_ramp_step: assert property (p_ramp_step)
        else $error("ramp moved more than one step or off tick");

    property p_floor_at_min;
        on_flag[0] && (pwm_source[0] == 2'b00)
            && (temp_latch[0] == signed'(fan_on_temperature[0]))
            |-> target[0] == floor_duty[0];
    endproperty
    a_floor_at_min: assert property (p_floor_at_min)
        else $error("target at on temperature is not floor duty");

    property p_reset_limits;
        $fell(reset) |-> (crit_limit[0] == RST_LIMIT[0])
            && (crit_limit[3] == RST_LIMIT[3]) && (max_duty[0] == DUTY_FULL);
    endproperty
    a_reset_limits: assert property (p_reset_limits)
        else $error("limit registers left reset with wrong value");

    property p_flag_follows;
        temp_valid[1] && chk_over1 |=> ##1 overtemperature_flag;
    endproperty
    a_flag_follows: assert property (p_flag_follows)
        else $error("flag not raised two edges after reading over limit");

    property p_ramp_hold;
        !ramp_tick |=> ramp_duty[0] == $past(ramp_duty[0]);
    endproperty
    a_ramp_hold: assert property (p_ramp_hold)
        else $error("ramp moved without a tick");

    property p_off_target;
        !on_flag[0] && (pwm_source[0] == 2'b00) |-> target[0] == DUTY_OFF;
    endproperty
    a_off_target: assert property (p_off_target)
        else $error("target not off while fan is off");

    c_crit_enter: cover property ($rose(crit_any));
    c_crit_leave: cover property ($fell(crit_any));
    c_fan_start: cover property ($rose(on_flag[0]));
    c_ramp_settle: cover property (ramp_tick && (ramp_duty[0] != 8'h00)
        && (ramp_duty[0] == target[0]));
    c_ceiling_clip: cover property (!crit_any
        && (ramp_duty[1] > max_duty[1]));

endmodule : afcl_top

`default_nettype wire

// ==== verification/afcl_fan_model.sv ====
// fan partner model: rotor speed follows the pwm drive
`timescale 1ns/10ps
`default_nettype none

module afcl_fan_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] duty,
    output logic [7:0] speed
);
    ////////////////////////////////////////////////////////////////////////
    // rotor inertia: one count of speed per cycle toward the drive
    always_ff @(posedge clk) begin
        if (reset) begin
            speed <= 8'h00;
        end else if (speed < duty) begin
            speed <= speed + 8'h01;
        end else if (speed > duty) begin
            speed <= speed - 8'h01;
        end
    end
endmodule : afcl_fan_model

`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the fan curve limit block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    num_errors++; $display("[ERR] %0t got %0h want %0h", $time, a, b); \
    end end

module tb;
    import afcl_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic [NUM_CH-1:0][7:0] temp_value = '0;
    logic [NUM_CH-1:0] temp_valid = '0;
    logic [NUM_CH-1:0][7:0] fan_on_temperature = '0;
    logic [NUM_PWM-1:0][7:0] floor_duty = '0;
    logic [NUM_PWM-1:0][SEL_W-1:0] pwm_source = {2'h2, 2'h1, 2'h0};
    logic [15:0] ramp_step_cycles = 16'h0000;
    logic [NUM_PWM-1:0][7:0] pwm_duty;
    logic [NUM_PWM-1:0][7:0] fan_speed;
    logic overtemperature_flag;
    int num_errors = 0;
    int check_count = 0;
    int mx [NUM_PWM] = '{255, 255, 255};
    int lim [NUM_CH] = '{100, 100, 100, 0};
    int hy [NUM_CH] = '{4, 4, 4, 4};
    int sp [NUM_CH] = '{192, 192, 192, 192};
    int on [NUM_CH] = '{0, 0, 0, 0};
    int crit [NUM_CH] = '{0, 0, 0, 0};
    int lt [NUM_CH] = '{0, 0, 0, 0};
    int sq [5];
    int v;
    int c;
    int tm;

    always #5 clk = ~clk;

    afcl_top i_afcl_top (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .temp_value(temp_value),
        .temp_valid(temp_valid), .fan_on_temperature(fan_on_temperature),
        .floor_duty(floor_duty), .pwm_source(pwm_source),
        .ramp_step_cycles(ramp_step_cycles), .pwm_duty(pwm_duty),
        .overtemperature_flag(overtemperature_flag));

    for (genvar g = 0; g < NUM_PWM; g++) begin : g_fan
        afcl_fan_model i_afcl_fan_model (.clk(clk), .reset(reset),
            .duty(pwm_duty[g]), .speed(fan_speed[g]));
    end

    ////////////////////////////////////////////////////////////////////////
    // bus tasks and reference model
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk) #1;
        reg_write = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        reg_addr = a;
        reg_read = 1'b1;
        @(posedge clk) #1;
        reg_read = 1'b0;
        `CHK(reg_rdata, e)
    endtask : rd

    task automatic send(input int ch, input int t);
        int tn;
        tn = int'(fan_on_temperature[ch]);
        @(posedge clk) #1;
        temp_value[ch] = 8'(t);
        temp_valid[ch] = 1'b1;
        @(posedge clk) #1;
        temp_valid[ch] = 1'b0;
        lt[ch] = t;
        if (t > lim[ch]) crit[ch] = 1;
        else if (t < lim[ch] - hy[ch]) crit[ch] = 0;
        if (t > tn) on[ch] = 1;
        else if (t < tn - hy[ch]) on[ch] = 0;
    endtask : send

    function automatic int exp_duty(input int p);
        int ch;
        int f;
        int t;
        ch = int'(pwm_source[p]);
        f = int'(floor_duty[p]);
        t = int'(fan_on_temperature[ch]);
        if (crit.sum() > 0) return 255;
        if (on[ch] == 0) return 0;
        t = (lt[ch] > t) ? f + (lt[ch] - t) * 6 * (255 - f) / sp[ch] : f;
        if (t > 255) t = 255;
        return (t < mx[p]) ? t : mx[p];
    endfunction : exp_duty

    task automatic chk_all;
        for (int p = 0; p < NUM_PWM; p++) `CHK(pwm_duty[p], 8'(exp_duty(p)))
    endtask : chk_all

    task automatic chk_fan;
        for (int p = 0; p < NUM_PWM; p++) `CHK(fan_speed[p], 8'(exp_duty(p)))
    endtask : chk_fan

    task automatic results;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        v = $urandom(32'hE2F4);
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        for (int i = 0; i < NUM_PWM; i++) rd(ADDR_MAX_DUTY[i], 8'hFF);
        for (int i = 0; i < NUM_CH; i++) rd(ADDR_RANGE[i], 8'hC0);
        for (int i = 0; i < 3; i++) rd(ADDR_LIMIT[i], 8'h64);
        rd(ADDR_LIMIT[3], 8'h00);
        rd(ADDR_HYST_A, 8'h44);
        rd(ADDR_HYST_B, 8'h44);
        rd(8'h37, 8'h00);
        `CHK(pwm_duty, 24'h000000)
        $display("test reset_values done");
        for (int i = 0; i < NUM_CH; i++) begin
            fan_on_temperature[i] = 8'(20 + $urandom % 20);
            hy[i] = 1 + $urandom % 15;
        end
        for (int i = 0; i < NUM_PWM; i++) floor_duty[i] = 8'(40 + $urandom % 80);
        wr(ADDR_LIMIT[3], 8'h7F);
        lim[3] = 127;
        wr(ADDR_HYST_A, 8'(hy[0] * 16 + hy[1]));
        wr(ADDR_HYST_B, 8'(hy[2] * 16 + hy[3]));
        rd(ADDR_HYST_A, 8'(hy[0] * 16 + hy[1]));
        rd(ADDR_HYST_B, 8'(hy[2] * 16 + hy[3]));
        for (int k = 0; k < 16; k++) begin
            c = k % 3;
            wr(ADDR_RANGE[c], 8'(k * 16));
            sp[c] = int'(SPAN_SIXTHS[k]);
            mx[c] = 64 + $urandom % 192;
            wr(ADDR_MAX_DUTY[c], 8'(mx[c]));
            rd(ADDR_MAX_DUTY[c], 8'(mx[c]));
            send(c, int'(fan_on_temperature[c]) + 1 + $urandom % 60);
            repeat (300) @(posedge clk) #1;
            chk_all();
            chk_fan();
        end
        $display("test curve_codes done");
        tm = int'(fan_on_temperature[0]);
        for (int r = 0; r < 2; r++) begin
            if (r == 1) begin
                wr(ADDR_HYST_A, 8'(hy[1]));
                hy[0] = 0;
            end
            if (r == 0) sq = '{tm + 3, tm, tm - hy[0], tm - hy[0] - 1, tm};
            else sq = '{tm + 2, tm - 1, tm + 2, tm, tm - 1};
            for (int i = 0; i < 5; i++) begin
                send(0, sq[i]);
                repeat (300) @(posedge clk) #1;
                chk_all();
                chk_fan();
            end
        end
        $display("test hysteresis done");
        ramp_step_cycles = 16'h0009;
        wr(ADDR_RANGE[0], 8'hF0);
        sp[0] = 480;
        send(0, tm + 40);
        repeat (30) @(posedge clk) #1;
        `CHK(pwm_duty[0] <= 8'h04 && pwm_duty[0] != 8'h00, 1'b1)
        repeat (3000) @(posedge clk) #1;
        chk_all();
        chk_fan();
        ramp_step_cycles = 16'h0000;
        $display("test ramp done");
        pwm_source[2] = 2'h3;
        send(3, int'(fan_on_temperature[3]) + 1 + $urandom % 60);
        repeat (300) @(posedge clk) #1;
        chk_all();
        chk_fan();
        $display("test cpu_bus_source done");
        wr(ADDR_LIMIT[1], 8'h50);
        lim[1] = 80;
        mx[1] = 48;
        wr(ADDR_MAX_DUTY[1], 8'h30);
        sq = '{81, 80 - hy[1], 79 - hy[1], 81, 60};
        for (int i = 0; i < 5; i++) begin
            send(1, sq[i]);
            @(posedge clk);
            @(posedge clk) #1;
            `CHK(overtemperature_flag, 1'(crit.sum() > 0))
            if (crit.sum() > 0) chk_all();
            repeat (300) @(posedge clk) #1;
            chk_all();
            chk_fan();
        end
        $display("test override done");
        results();
    end

    initial begin
        #300000;
        num_errors++;
        results();
    end
endmodule : tb

`default_nettype wire
